// File: pwm_pkg.sv
package pwm_pkg;

    localparam int CLK_HZ = 100_000_000;
    localparam int TICK_NS = 1000;
    localparam int CLK_PERIOD_NS = 10;
    // Cycles per microsecond tick
    localparam int TICK_CYCLES = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WORD_W = 16;
    localparam logic [15:0] PERIOD_MIN = 16'h000a;
    localparam logic [15:0] DUTY_OFF = 16'h0000;
    localparam logic [15:0] DUTY_ON = 16'hffff;
    localparam logic [15:0] DUTY_RESET = 16'h0000;
    localparam logic [15:0] PERIOD_RESET = 16'h03e8;
    localparam int PAIRING_INDEX = 16'h8020;
    localparam int PAIRING_SUBINDEX = 8'h09;

    typedef enum logic [1:0] {
        independent_channels,
        follow_first_channel,
        follow_first_inverted
    } pairing_mode_t;

    typedef struct packed {
        logic [15:0] duty;
        logic [15:0] period;
    } channel_cfg_t;

endpackage

// File: pwm_channel.sv
`timescale 1ns/1ps
module pwm_channel
    import pwm_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic tick,
    input pwm_pkg::channel_cfg_t cfg,
    output logic pwm_out
);
    logic [15:0] period_reg, period_next;
    logic [15:0] duty_reg, duty_next;
    logic [15:0] count_reg, count_next;
    logic [31:0] high_len;
    logic out_next;
    logic wrap;

    // High time in ticks = period*duty/65535, rounded down
    always_comb
    begin
        wrap = tick && (count_reg >= period_reg - 16'h0001);
        period_next = period_reg;
        duty_next = duty_reg;
        count_next = count_reg;
        if (tick)
        begin
            count_next = wrap ? 16'h0000 : count_reg + 16'h0001;
        end
        if (wrap)
        begin
            // Latch only at period boundary to avoid runt pulses
            period_next = (cfg.period <= PERIOD_MIN) ? PERIOD_MIN : cfg.period;
            duty_next = cfg.duty;
        end
        // Level from the words in force after this edge, so a reload never leaves a runt
        high_len = (32'(period_next) * 32'(duty_next)) / 32'(DUTY_ON);
        if (duty_next == DUTY_OFF)
        begin
            out_next = 1'b0;
        end
        else if (duty_next == DUTY_ON)
        begin
            out_next = 1'b1;
        end
        else
        begin
            out_next = 32'(count_next) < high_len;
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            period_reg <= PERIOD_MIN;
            duty_reg <= DUTY_RESET;
            count_reg <= 16'h0000;
            pwm_out <= 1'b0;
        end
        else
        begin
            period_reg <= period_next;
            duty_reg <= duty_next;
            count_reg <= count_next;
            pwm_out <= out_next;
        end
    end
endmodule

// File: dual_channel_pwm_outputs.sv
`timescale 1ns/1ps
module dual_channel_pwm_outputs
    import pwm_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input pwm_pkg::channel_cfg_t ch1_cfg,
    input pwm_pkg::channel_cfg_t ch2_cfg,
    input pwm_pkg::pairing_mode_t pairing_mode,
    output logic pwm_out1,
    output logic pwm_out2,
    output logic led1,
    output logic led2
);
    import pwm_pkg::*;

    localparam int NUM_CHANNELS = 2;
    // Divider count that raises the microsecond tick
    localparam logic [7:0] DIV_LAST = 8'(TICK_CYCLES - 1);

    // Level shown on channel two for a pairing mode
    function automatic logic paired_level
    (
        input pairing_mode_t mode,
        input logic own,
        input logic lead
    );
        logic level;

        level = own;
        case (mode)
            independent_channels:
            begin
                level = own;
            end
            follow_first_channel:
            begin
                level = lead;
            end
            follow_first_inverted:
            begin
                // Complement, so a rise on one is a fall on two
                level = ~lead;
            end
            default:
            begin
                level = own;
            end
        endcase
        return level;
    endfunction

    // Unused code folds to independent so a stray value cannot slave channel two
    function automatic pairing_mode_t legal_mode
    (
        input pairing_mode_t code
    );
        pairing_mode_t result;

        case (code)
            independent_channels:
            begin
                result = independent_channels;
            end
            follow_first_channel:
            begin
                result = follow_first_channel;
            end
            follow_first_inverted:
            begin
                result = follow_first_inverted;
            end
            default:
            begin
                // Code 3 is reserved
                result = independent_channels;
            end
        endcase
        return result;
    endfunction

    logic [7:0] div_reg;
    logic [7:0] div_next;
    logic tick;

    // One microsecond tick shared by both channels keeps them phase aligned
    always_comb
    begin
        tick = (div_reg == DIV_LAST);
        if (tick)
        begin
            div_next = 8'h00;
        end
        else
        begin
            div_next = div_reg + 8'h01;
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            div_reg <= 8'h00;
        end
        else
        begin
            div_reg <= div_next;
        end
    end

    pairing_mode_t mode_reg;
    pairing_mode_t mode_next;

    // Mode sampled every cycle; a change shows two cycles later
    always_comb
    begin
        mode_next = legal_mode(pairing_mode);
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            mode_reg <= independent_channels;
        end
        else
        begin
            mode_reg <= mode_next;
        end
    end

    // Indexed per channel so both instances come from one loop
    channel_cfg_t cfg_in [NUM_CHANNELS];
    wire logic [NUM_CHANNELS-1:0] raw;

    always_comb
    begin
        cfg_in[0] = ch1_cfg;
        cfg_in[1] = ch2_cfg;
    end

    generate
        for (genvar ch = 0; ch < NUM_CHANNELS; ch++)
        begin : g_channel
            // Each channel keeps its own words and period counter
            pwm_channel u_chan (
                .clk(clk),
                .sys_rst(sys_rst),
                .tick(tick),
                .cfg(cfg_in[ch]),
                .pwm_out(raw[ch])
            );
        end
    endgenerate

    logic [NUM_CHANNELS-1:0] out_reg;
    logic [NUM_CHANNELS-1:0] out_next;

    // Channel one passes one flop too, so paired edges stay coincident
    always_comb
    begin
        out_next[0] = raw[0];
        out_next[1] = paired_level(mode_reg, raw[1], raw[0]);
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            out_reg <= '0;
        end
        else
        begin
            out_reg <= out_next;
        end
    end

    logic [NUM_CHANNELS-1:0] led_reg;
    logic [NUM_CHANNELS-1:0] led_next;

    // Own flop keeps LED wiring off the output net
    always_comb
    begin
        led_next[0] = raw[0];
        led_next[1] = paired_level(mode_reg, raw[1], raw[0]);
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            led_reg <= '0;
        end
        else
        begin
            led_reg <= led_next;
        end
    end

    // Ports mirror the flops, so outputs carry no decode glitches
    always_comb
    begin
        pwm_out1 = out_reg[0];
        pwm_out2 = out_reg[1];
        led1 = led_reg[0];
        led2 = led_reg[1];
    end
endmodule

// File: pwm_props.sv
`timescale 1ns/1ps
module pwm_props
    import pwm_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input pwm_pkg::pairing_mode_t pairing_mode,
    input wire logic pwm_out1,
    input wire logic pwm_out2,
    input wire logic led1,
    input wire logic led2
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Four cycles covers the two-cycle mode latency
    sequence s_fol; (pairing_mode == follow_first_channel)[*4]; endsequence
    sequence s_inv; (pairing_mode == follow_first_inverted)[*4]; endsequence
    property p_led1; led1 == pwm_out1; endproperty
    property p_led2; led2 == pwm_out2; endproperty
    property p_fol; s_fol |-> pwm_out2 == pwm_out1; endproperty
    property p_inv; s_inv |-> pwm_out2 != pwm_out1; endproperty
    property p_rst; disable iff (1'b0) sys_rst |=> !pwm_out1 && !pwm_out2; endproperty
    property p_gap; $rose(pwm_out1) |=> not (##[0:997] $rose(pwm_out1)); endproperty
    property p_hold; $rose(pwm_out1) |=> pwm_out1[*8]; endproperty
    property p_ledr; $fell(pwm_out2) |-> $fell(led2); endproperty
    a_led1: assert property (p_led1) else $error("led1 differs");
    a_led2: assert property (p_led2) else $error("led2 differs");
    a_fol: assert property (p_fol) else $error("follow broken");
    a_inv: assert property (p_inv) else $error("inverse broken");
    a_rst: assert property (p_rst) else $error("not low in reset");
    a_gap: assert property (p_gap) else $error("period too short");
    a_hold: assert property (p_hold) else $error("pulse too short");
    a_ledr: assert property (p_ledr) else $error("led2 edge late");
endmodule
bind dual_channel_pwm_outputs pwm_props props_u (.*);

// File: load_model.sv
`timescale 1ns/1ps
module load_model
(
    input wire logic clk,
    input wire logic drive,
    output int high_cnt,
    output int period_cnt
);
    int hi_acc = 0;
    int per_acc = 0;
    logic last = 1'b1;
    always @(posedge clk)
    begin
        last <= drive;
        per_acc <= (drive && !last) ? 1 : per_acc + 1;
        hi_acc <= (drive && !last) ? 1 : hi_acc + int'(drive);
        if (drive && !last)
        begin
            high_cnt <= hi_acc;
            period_cnt <= per_acc;
        end
    end
endmodule

// File: dual_channel_pwm_outputs_tb.sv
`timescale 1ns/1ps
module dual_channel_pwm_outputs_tb;
    import pwm_pkg::*;
    logic clk = 0;
    logic sys_rst = 1;
    channel_cfg_t ch1_cfg = '0;
    channel_cfg_t ch2_cfg = '0;
    pairing_mode_t pairing_mode = independent_channels;
    logic pwm_out1, pwm_out2, led1, led2;
    int hi1, per1, hi2, per2;
    int bad_count = 0;
    int total_checks = 0;
    dual_channel_pwm_outputs dut_u (.*);
    load_model l1_u (.clk(clk), .drive(pwm_out1), .high_cnt(hi1), .period_cnt(per1));
    load_model l2_u (.clk(clk), .drive(pwm_out2), .high_cnt(hi2), .period_cnt(per2));
    initial forever #5 clk = ~clk;
    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("wrong value t=%0t got %0d exp %0d", $time, got, exp);
        end
    endtask
    task conclude;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task t_reset;
        chk({pwm_out1, pwm_out2}, 0);
        sys_rst = 0;
        repeat (500) @(negedge clk);
        chk({pwm_out1, pwm_out2, led1, led2}, 0);
        $display("reset done");
    endtask
    task t_indep;
        int rises;
        logic prev2;
        ch1_cfg = '{16'h7fff, 16'h0003};
        ch2_cfg = '{16'h7fff, 16'h0014};
        repeat (6000) @(negedge clk);
        chk(per1, 1000);
        chk(hi1, (10 * 32767 / 65535) * 100);
        chk(per2, 2000);
        chk(hi2, (20 * 32767 / 65535) * 100);
        ch1_cfg = '{16'hffff, 16'h0014};
        ch2_cfg = '{16'h0000, 16'h0014};
        rises = 0;
        prev2 = pwm_out2;
        repeat (4200) @(negedge clk)
        begin
            rises += int'(pwm_out2 && !prev2);
            prev2 = pwm_out2;
        end
        chk(rises, 0);
        chk({pwm_out1, led1, pwm_out2, led2}, 4'hc);
        $display("independent done");
    endtask
    task t_pair;
        int n;
        ch1_cfg = '{16'h7fff, 16'h0014};
        for (int m = 1; m < 3; m++)
        begin
            @(negedge clk) pairing_mode = pairing_mode_t'(m);
            repeat (4) @(negedge clk);
            n = 0;
            repeat (4000) @(negedge clk) n += int'((pwm_out2 ^ (m == 2)) !== pwm_out1);
            chk(n, 0);
        end
        $display("pairing done");
    endtask
    initial
    begin
        repeat (3) @(negedge clk);
        t_reset;
        t_indep;
        t_pair;
        conclude;
    end
    initial
    begin
        #400_000;
        bad_count++;
        conclude;
    end
endmodule
